//--- design/mbi_bus_port.sv
// Host bus port: strobe decode, address latch, lane steering, store.
// Assumes pins come from the host asynchronously and cfg is static.
// Summary of operation
// - Read and write pins take several strobe roles
// - Byte control and lowest pin take roles
// - Multiplexed host lines meet combined port directly
// - Latch enable captures address off shared lines
// - Read data driven after the access time
// - Combined port released when nothing selected
// - Non-multiplexed: address combined port, data ports
// - Optional address latch in non-multiplexed mode
// - Data ports released when host not accessing
// - Eight-bit bus: one byte, low lanes
// - High enable with bit zero picks lanes
// - Separate high and low write strobes
// - Size bit scheme, even bytes upper lanes
// - Upper and lower data strobes steer lanes
// - First port high address, latched when multiplexed
// - Other port address inputs: unlatched, general only
// - Latched low address out on five ports
// - Program store enable reads, latch enable high
// - Enable clock with R/W makes internal strobes
// - Host reset output derived from own reset
// - Spare pins return ready and bus width
`timescale 1ns/10ps
`include "mbi_defines.svh"
module mbi_bus_port (
	input wire logic clock,
	input wire logic nrst,
	input mbi_pkg::mbi_cfg_s cfg,
	input wire logic rd_pin,
	input wire logic wr_pin,
	input wire logic byte_control_pin,
	input wire logic latch_enable_pin,
	input wire logic [15:0] combined_addr_data_port_in,
	output logic [15:0] combined_addr_data_port_out,
	output logic [15:0] combined_addr_data_port_oe,
	input wire logic [7:0] port_c_in,
	output logic [7:0] port_c_out,
	output logic [7:0] port_c_oe,
	input wire logic [7:0] port_d_in,
	output logic [7:0] port_d_out,
	output logic [7:0] port_d_oe,
	input wire logic [7:0] port_a_addr_in,
	input wire logic [7:0] ext_addr_in,
	output logic ext_addr_hit,
	output logic [39:0] addr_out_port,
	output logic [4:0] addr_out_oe,
	output logic host_reset_output,
	output logic wait_ready_out,
	output logic bus_width_signal,
	output logic spare_oe
);
	localparam int ACC = `MBI_ACCESS_CYC;
	mbi_pkg::mbi_pins_s pin_raw;
	mbi_pkg::mbi_pins_s pin_meta;
	mbi_pkg::mbi_pins_s pin_s;
	mbi_pkg::mbi_lane_s lanes;
	mbi_pkg::mbi_lane_s rd_lanes;
	mbi_pkg::mbi_lane_s wr_lanes;
	mbi_pkg::mbi_strobe_s strobes;
	mbi_pkg::mbi_state_e state;
	mbi_pkg::mbi_state_e next_state;
	logic [`MBI_CNT_W-1:0] cnt;
	logic [`MBI_CNT_W-1:0] next_cnt;
	logic [`MBI_ADDR_W-1:0] latched;
	logic [15:0] mem [0:`MBI_MEM_WORDS-1];
	logic [15:0] out_q;
	logic [15:0] addr_out_q;
	logic [7:0] w_even;
	logic [7:0] w_odd;
	logic [5:0] w_idx;
	logic wr_q;
	logic [1:0] rst_sync;
	wire logic ale_on;
	wire logic latch_use;
	wire logic [`MBI_ADDR_W-1:0] live_addr;
	wire logic [`MBI_ADDR_W-1:0] addr;
	wire logic lowest_address_pin;
	wire logic hi_ok;
	wire logic data_sel;
	wire logic prog_sel;
	wire logic sel;
	wire logic rd_hit;
	wire logic wr_hit;
	wire logic commit;
	wire logic [5:0] idx;
	wire logic [15:0] word;
	wire logic [15:0] src;
	wire logic [15:0] steered;
	wire logic lo_on;
	wire logic hi_on;
	wire logic driving;

	// Every pin passes two flops; the host holds buses steady around strobes
	assign pin_raw = '{rd: rd_pin, wr: wr_pin, bc: byte_control_pin,
		le: latch_enable_pin, addr_data: combined_addr_data_port_in,
		pc: port_c_in, pd: port_d_in, pa: port_a_addr_in,
		ext: ext_addr_in};
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pin_meta <= '0;
			pin_s <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin_s <= pin_meta;
		end
	end

	// Address source: latch in multiplexed mode or when asked for
	assign ale_on = cfg.ale_high ? pin_s.le : !pin_s.le;
	assign latch_use = cfg.mux_mode || cfg.latch_nonmux;
	assign live_addr = {pin_s.pa, pin_s.addr_data};
	assign addr = latch_use ? latched : live_addr;
	assign lowest_address_pin = addr[0];

	// Transparent while enable is active, frozen once it falls
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			latched <= `MBI_LATCH_RST;
		end else if (ale_on) begin
			latched <= live_addr;
		end
	end

	mbi_lane_decode u_lanes (
		.cfg(cfg),
		.rd_pin(pin_s.rd),
		.wr_pin(pin_s.wr),
		.byte_control_pin(pin_s.bc),
		.a0(lowest_address_pin),
		.lanes(lanes),
		.strobes(strobes)
	);

	// Decode: only the first port's high bits reach data and program selection
	assign hi_ok = !cfg.addr_in_en || addr[23:16] == cfg.page;
	assign data_sel = hi_ok &&
		addr[`MBI_BASE_HI:`MBI_BASE_LO] == cfg.data_base;
	assign prog_sel = hi_ok &&
		addr[`MBI_BASE_HI:`MBI_BASE_LO] == cfg.prog_base;
	assign sel = strobes.prog ? prog_sel : data_sel;
	assign rd_hit = strobes.rd && sel;
	assign wr_hit = strobes.wr && sel && !strobes.rd;
	assign idx = addr[`MBI_IDX_HI:`MBI_IDX_LO];
	assign word = mem[idx];

	// Other-port address inputs: compared live, never latched
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ext_addr_hit <= 1'b0;
		end else begin
			ext_addr_hit <= pin_s.ext == cfg.ext_match;
		end
	end

	// Read sequence: wait the access time, then drive
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			mbi_pkg::MBI_IDLE: begin
				next_cnt = '0;
				if (rd_hit) begin
					next_state = mbi_pkg::MBI_WAIT;
				end
			end
			mbi_pkg::MBI_WAIT: begin
				if (!rd_hit) begin
					next_state = mbi_pkg::MBI_IDLE;
				end else if (cnt == `MBI_CNT_W'(ACC - 1)) begin
					next_state = mbi_pkg::MBI_DRIVE;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			mbi_pkg::MBI_DRIVE: begin
				if (!strobes.rd) begin
					next_state = mbi_pkg::MBI_IDLE;
				end
			end
			default: begin
				next_state = mbi_pkg::MBI_IDLE;
			end
		endcase
	end

	// Read steering: even byte upper only for swapped schemes
	assign steered = !cfg.bus16 ?
		{8'h00, lowest_address_pin ? word[15:8] : word[7:0]} :
		(lanes.swap ? {word[7:0], word[15:8]} : word);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= mbi_pkg::MBI_IDLE;
			cnt <= '0;
			out_q <= `MBI_DATA_RST;
			rd_lanes <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			if (next_state == mbi_pkg::MBI_DRIVE &&
				state == mbi_pkg::MBI_WAIT) begin
				out_q <= steered;
				rd_lanes <= lanes;
			end
		end
	end

	// Output enables: physical lane from byte enable and swap
	assign driving = state == mbi_pkg::MBI_DRIVE;
	assign lo_on = driving && (!cfg.bus16 || (rd_lanes.swap ?
		rd_lanes.odd_en : rd_lanes.even_en));
	assign hi_on = driving && cfg.bus16 && (rd_lanes.swap ?
		rd_lanes.even_en : rd_lanes.odd_en);
	assign combined_addr_data_port_out = out_q;
	assign combined_addr_data_port_oe = cfg.mux_mode ?
		{{8{hi_on}}, {8{lo_on}}} : 16'h0000;
	assign port_c_out = out_q[7:0];
	assign port_d_out = out_q[15:8];
	assign port_c_oe = {8{!cfg.mux_mode && lo_on}};
	assign port_d_oe = {8{!cfg.mux_mode && hi_on}};

	// Write capture; commit at strobe end when data has settled
	assign src = cfg.mux_mode ? pin_s.addr_data : {pin_s.pd, pin_s.pc};
	assign commit = wr_q && !wr_hit;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_q <= 1'b0;
			w_even <= 8'h00;
			w_odd <= 8'h00;
			w_idx <= 6'h00;
			wr_lanes <= '0;
		end else begin
			wr_q <= wr_hit;
			if (wr_hit) begin
				w_even <= (cfg.bus16 && lanes.swap) ? src[15:8] : src[7:0];
				w_odd <= (cfg.bus16 && !lanes.swap) ? src[15:8] : src[7:0];
				w_idx <= idx;
				wr_lanes <= lanes;
			end
		end
	end

	// Store has no reset; only enabled bytes change
	always_ff @(posedge clock) begin
		if (commit && wr_lanes.even_en) begin
			mem[w_idx][7:0] <= w_even;
		end
		if (commit && wr_lanes.odd_en) begin
			mem[w_idx][15:8] <= w_odd;
		end
	end

	// Address out, ready, width and host reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			addr_out_q <= 16'h0000;
			rst_sync <= 2'b00;
			wait_ready_out <= 1'b0;
			bus_width_signal <= 1'b0;
		end else begin
			addr_out_q <= latched[15:0];
			rst_sync <= {rst_sync[0], 1'b1};
			wait_ready_out <= next_state != mbi_pkg::MBI_WAIT;
			bus_width_signal <= cfg.bus16;
		end
	end
	// Host leaves reset two clocks after this block does
	assign host_reset_output = cfg.rst_out_high ?
		!rst_sync[1] : rst_sync[1];
	assign spare_oe = cfg.spare_en;
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			addr_out_port[i*8 +: 8] = cfg.addr_out_hi[i] ?
				addr_out_q[15:8] : addr_out_q[7:0];
			addr_out_oe[i] = cfg.mux_mode && cfg.addr_out_en[i];
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	chk_wait_count: assert property (
		$rose(driving) |-> $past(cnt) == `MBI_CNT_W'(ACC - 1)
	) else $error("read data driven before the access time");
	chk_combined_idle: assert property (
		(|combined_addr_data_port_oe) |-> cfg.mux_mode && $past(rd_hit)
	) else $error("combined port driven while unselected");
	chk_data_quiet: assert property (
		(|{port_c_oe, port_d_oe}) |-> !cfg.mux_mode && $past(strobes.rd)
	) else $error("data port driven without a host read");
	chk_latch_hold: assert property (
		!ale_on && $past(!ale_on) |-> $stable(latched)
	) else $error("address latch moved while closed");
	chk_latch_take: assert property (
		ale_on |=> latched == $past(live_addr)
	) else $error("address latch missed the shared lines");
	chk_narrow_bus: assert property (
		!cfg.bus16 |-> port_d_oe == 8'h00 &&
		combined_addr_data_port_oe[15:8] == 8'h00
	) else $error("upper lanes driven on an eight-bit bus");
	chk_high_enable: assert property (
		cfg.bus16 && cfg.bc_role == mbi_pkg::MBI_BC_HIGH_EN |->
		lanes.odd_en == !pin_s.bc && lanes.even_en == !addr[0]
	) else $error("high enable lane choice wrong");
	chk_byte_keep: assert property (
		commit && !wr_lanes.odd_en |=>
		mem[$past(w_idx)][15:8] == $past(mem[w_idx][15:8])
	) else $error("disabled upper byte was written");
	chk_eclk_read: assert property (
		cfg.rd_role == mbi_pkg::MBI_RD_ECLK &&
		cfg.wr_role == mbi_pkg::MBI_WR_RNW && pin_s.rd |->
		strobes.rd == pin_s.wr && strobes.wr == !pin_s.wr
	) else $error("enable clock strobes derived wrongly");
	chk_addr_out: assert property (
		(|addr_out_oe) |-> cfg.mux_mode
	) else $error("address out enabled without multiplexed bus");
	chk_ready_low: assert property (
		state == mbi_pkg::MBI_WAIT && next_state == mbi_pkg::MBI_WAIT
		|=> !wait_ready_out
	) else $error("ready not withdrawn during access wait");
	cov_mux_read: cover property (
		$rose(driving) && cfg.mux_mode && cfg.bus16);
	cov_nonmux_write: cover property (commit && !cfg.mux_mode);
	cov_swap_read: cover property ($rose(driving) && lanes.swap);
endmodule

//--- design/mbi_defines.svh
// Constants for the host bus port: timing counts, widths, reset values.
// Assumes a single 40 MHz clock drives every flip-flop of the block.
`ifndef MBI_DEFINES_SVH
`define MBI_DEFINES_SVH
`define MBI_CLK_NS 25
// Access time from strobe to driven read data, in ns
`define MBI_ACCESS_NS 100
// Least time, so round up to whole cycles
`define MBI_ACCESS_CYC ((`MBI_ACCESS_NS + `MBI_CLK_NS - 1) / `MBI_CLK_NS)
`define MBI_CNT_W 3
// Internal store: 64 words of 16 bits, byte address bits 6:1 index it
`define MBI_MEM_WORDS 64
`define MBI_IDX_HI 6
`define MBI_IDX_LO 1
`define MBI_BASE_HI 15
`define MBI_BASE_LO 7
`define MBI_BASE_W 9
`define MBI_ADDR_W 24
`define MBI_LATCH_RST 24'h000000
`define MBI_DATA_RST 16'h0000
`endif

//--- design/mbi_pkg.sv
// Types shared by the host bus port and its lane decoder.
// Assumes the configuration word is held stable by the system.
package mbi_pkg;
	// Role of the read pin
	typedef enum logic [1:0] {
		MBI_RD_READ = 2'b00,
		MBI_RD_ECLK = 2'b01,
		MBI_RD_DS = 2'b10,
		MBI_RD_LOW_DS = 2'b11
	} mbi_rd_role_e;
	// Role of the write pin
	typedef enum logic [1:0] {
		MBI_WR_WRITE = 2'b00,
		MBI_WR_RNW = 2'b01,
		MBI_WR_LOW_WR = 2'b10
	} mbi_wr_role_e;
	// Role of the byte control pin
	typedef enum logic [2:0] {
		MBI_BC_HIGH_EN = 3'b000,
		MBI_BC_PROG_EN = 3'b001,
		MBI_BC_HIGH_WR = 3'b010,
		MBI_BC_UPPER_DS = 3'b011,
		MBI_BC_SIZE = 3'b100
	} mbi_bc_role_e;
	// Role of the lowest address pin
	typedef enum logic {
		MBI_A0_ADDR = 1'b0,
		MBI_A0_LOW_EN = 1'b1
	} mbi_a0_role_e;
	// Read access sequence
	typedef enum logic [1:0] {
		MBI_IDLE = 2'b00,
		MBI_WAIT = 2'b01,
		MBI_DRIVE = 2'b10
	} mbi_state_e;
	typedef struct packed {
		logic mux_mode;
		logic bus16;
		mbi_rd_role_e rd_role;
		mbi_wr_role_e wr_role;
		mbi_bc_role_e bc_role;
		mbi_a0_role_e a0_role;
		logic ale_high;
		logic latch_nonmux;
		logic addr_in_en;
		logic [4:0] addr_out_en;
		logic [4:0] addr_out_hi;
		logic [8:0] data_base;
		logic [8:0] prog_base;
		logic [7:0] page;
		logic [7:0] ext_match;
		logic spare_en;
		logic rst_out_high;
	} mbi_cfg_s;
	// Internal byte enables; swap puts the even byte on the upper lanes
	typedef struct packed {
		logic even_en;
		logic odd_en;
		logic swap;
	} mbi_lane_s;
	typedef struct packed {
		logic rd;
		logic wr;
		logic prog;
	} mbi_strobe_s;
	// Synchronised pin sample
	typedef struct packed {
		logic rd;
		logic wr;
		logic bc;
		logic le;
		logic [15:0] addr_data;
		logic [7:0] pc;
		logic [7:0] pd;
		logic [7:0] pa;
		logic [7:0] ext;
	} mbi_pins_s;
endpackage

//--- design/mbi_lane_decode.sv
// Strobe and byte lane decoder for the host bus port.
// Assumes its pin inputs are already synchronised to clock.
`timescale 1ns/10ps
module mbi_lane_decode (
	input mbi_pkg::mbi_cfg_s cfg,
	input wire logic rd_pin,
	input wire logic wr_pin,
	input wire logic byte_control_pin,
	input wire logic a0,
	output mbi_pkg::mbi_lane_s lanes,
	output mbi_pkg::mbi_strobe_s strobes
);
	wire logic rnw;
	wire logic main_on;
	wire logic upper_on;
	wire logic any_on;
	wire logic rd_cyc;
	wire logic wr_cyc;
	wire logic prog_cyc;

	// Host strobe styles folded into internal read and write
	assign rnw = cfg.wr_role == mbi_pkg::MBI_WR_RNW;
	assign main_on = (cfg.rd_role == mbi_pkg::MBI_RD_ECLK) ?
		rd_pin : !rd_pin;
	assign upper_on = (cfg.bc_role == mbi_pkg::MBI_BC_UPPER_DS) &&
		!byte_control_pin;
	assign any_on = main_on || upper_on;
	// Enable clock and R/W give both strobes; write is R/W low
	assign rd_cyc = rnw ? (any_on && wr_pin) : !rd_pin;
	assign prog_cyc = (cfg.bc_role == mbi_pkg::MBI_BC_PROG_EN) &&
		!byte_control_pin;
	assign wr_cyc = rnw ? (any_on && !wr_pin) :
		(!wr_pin || ((cfg.bc_role == mbi_pkg::MBI_BC_HIGH_WR) &&
		!byte_control_pin));
	assign strobes = '{rd: rd_cyc || prog_cyc, wr: wr_cyc, prog: prog_cyc};

	// Byte lane selection per scheme
	always_comb begin
		lanes = '{even_en: !a0, odd_en: a0, swap: 1'b0};
		if (cfg.bus16) begin
			case (cfg.bc_role)
				mbi_pkg::MBI_BC_HIGH_EN: begin
					// Same polarity whether the pin is A0 or low enable
					lanes.even_en = !a0;
					lanes.odd_en = !byte_control_pin;
				end
				mbi_pkg::MBI_BC_HIGH_WR: begin
					// Reads take the word; strobes pick bytes on writes
					lanes.even_en = !wr_cyc || !wr_pin;
					lanes.odd_en = !wr_cyc || !byte_control_pin;
				end
				mbi_pkg::MBI_BC_UPPER_DS: begin
					lanes.swap = 1'b1;
					lanes.even_en = !byte_control_pin;
					lanes.odd_en = !rd_pin;
				end
				mbi_pkg::MBI_BC_SIZE: begin
					lanes.swap = 1'b1;
					lanes.even_en = !a0;
					lanes.odd_en = a0 || !byte_control_pin;
				end
				default: begin
					// Program reads on a wide bus take the whole word
					lanes.even_en = 1'b1;
					lanes.odd_en = 1'b1;
				end
			endcase
		end
	end
endmodule

//--- bench/mbi_host_model.sv
// Host side of the external bus: strobes, latch enable, address, data.
// Assumes the bench resolves shared lines and feeds back the read data.
`timescale 1ns/10ps
module mbi_host_model (
	input wire logic clock,
	input wire logic mux,
	input wire logic [15:0] rdata,
	input wire logic rvalid,
	input wire logic ready,
	output logic rd_n,
	output logic wr_n,
	output logic bc_n,
	output logic ale,
	output logic [15:0] ad_bus,
	output logic [15:0] dbus,
	output logic [7:0] hi_addr
);
	// Idle levels; released lines get inverted so stale data never lingers
	initial begin
		rd_n = 1'b1;
		wr_n = 1'b1;
		bc_n = 1'b1;
		ale = 1'b0;
		ad_bus = 16'h0000;
		dbus = 16'hffff;
		hi_addr = 8'h00;
	end

	// Address phase; held past the latch drop to cover synchroniser lag
	task automatic addr_phase(input logic [23:0] a, input logic b);
		@(posedge clock);
		ad_bus <= a[15:0];
		hi_addr <= a[23:16];
		bc_n <= b;
		ale <= 1'b1;
		repeat (3) @(posedge clock);
		ale <= 1'b0;
		repeat (3) @(posedge clock);
	endtask

	// Write: data settles well before the strobe ends
	task automatic write(input logic [23:0] a, input logic b,
		input logic [15:0] d);
		addr_phase(a, b);
		if (mux) begin
			ad_bus <= d;
		end else begin
			dbus <= d;
		end
		wr_n <= 1'b0;
		repeat (5) @(posedge clock);
		wr_n <= 1'b1;
		repeat (4) @(posedge clock);
		ad_bus <= ~d;
		dbus <= ~d;
		bc_n <= 1'b1;
	endtask

	// Read: waits for the device to drive, bounded, then takes data
	task automatic read(input logic [23:0] a, input logic b,
		output logic [15:0] d, output int n, output logic w);
		addr_phase(a, b);
		if (mux) begin
			ad_bus <= ~a[15:0];
		end
		rd_n <= 1'b0;
		n = 0;
		w = 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (ready === 1'b0) begin
				w = 1'b0;
			end
		end while (rvalid !== 1'b1 && n < 12);
		d = rdata;
		rd_n <= 1'b1;
		bc_n <= 1'b1;
		repeat (4) @(posedge clock);
	endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the host bus port with a host model.
// Assumes the design files and package are compiled first.
`timescale 1ns/10ps
module testbench;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	mbi_pkg::mbi_cfg_s cfg;
	int fail_count = 0;
	int n_checks = 0;
	logic rd_n, wr_n, bc_n, ale, ext_hit, rst_host, wrdy, bw, spare;
	logic rd_drv;
	logic [15:0] hadio, hdbus, cad_out, cad_oe, cad_in, rdata;
	logic [7:0] hi_addr, pc_out, pc_oe, pd_out, pd_oe, pc_in, pd_in;
	logic [7:0] ext_in;
	logic [39:0] ao_port;
	logic [4:0] ao_oe;
	logic rvalid;
	logic [15:0] d;
	int n;
	logic w;

	// Shared lines: whoever enables wins, else the host level
	assign cad_in = (cad_oe & cad_out) | (~cad_oe & hadio);
	assign pc_in = (pc_oe & pc_out) | (~pc_oe & hdbus[7:0]);
	assign pd_in = (pd_oe & pd_out) | (~pd_oe & hdbus[15:8]);
	assign rdata = cfg.mux_mode ? cad_out : {pd_out, pc_out};
	assign rvalid = cfg.mux_mode ? (|cad_oe) : ((|pc_oe) | (|pd_oe));
	// Enable clock host: E high through either strobe, write line is R/W
	assign rd_drv = (cfg.rd_role == mbi_pkg::MBI_RD_ECLK) ?
		!(rd_n & wr_n) : rd_n;

	always #12.5 clock = ~clock;

	mbi_bus_port dut (.clock(clock), .nrst(nrst), .cfg(cfg),
		.rd_pin(rd_drv), .wr_pin(wr_n), .byte_control_pin(bc_n),
		.latch_enable_pin(ale), .combined_addr_data_port_in(cad_in),
		.combined_addr_data_port_out(cad_out),
		.combined_addr_data_port_oe(cad_oe),
		.port_c_in(pc_in), .port_c_out(pc_out), .port_c_oe(pc_oe),
		.port_d_in(pd_in), .port_d_out(pd_out), .port_d_oe(pd_oe),
		.port_a_addr_in(hi_addr), .ext_addr_in(ext_in),
		.ext_addr_hit(ext_hit), .addr_out_port(ao_port),
		.addr_out_oe(ao_oe), .host_reset_output(rst_host),
		.wait_ready_out(wrdy), .bus_width_signal(bw), .spare_oe(spare));

	mbi_host_model host (.clock(clock), .mux(cfg.mux_mode),
		.rdata(rdata), .rvalid(rvalid), .ready(wrdy), .rd_n(rd_n),
		.wr_n(wr_n), .bc_n(bc_n), .ale(ale), .ad_bus(hadio),
		.dbus(hdbus), .hi_addr(hi_addr));

	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t bit got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Reset with a new bus style; host reset must follow our own
	task automatic t_reset(input logic m, input logic wd);
		@(posedge clock);
		nrst <= 1'b0;
		cfg.mux_mode <= m;
		cfg.bus16 <= wd;
		repeat (3) @(posedge clock);
		chk_bit(rst_host, 1'b0);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		chk_bit(rst_host, 1'b1);
		chk_bit(bw, wd);
		chk_bit(wrdy, 1'b1);
		chk_bit(spare, 1'b1);
		$display("test reset done");
	endtask

	// Whole word, then each lane alone, over the shared lines
	task automatic t_mux_lanes();
		host.write(24'h000100, 1'b0, 16'h1234);
		host.read(24'h000100, 1'b0, d, n, w);
		chk_word(d, 16'h1234);
		chk_word(cad_oe, 16'h0000);
		chk_bit(w, 1'b0);
		chk_bit((n == 8) || (n == 9), 1'b1);
		host.write(24'h000101, 1'b0, 16'hab00);
		host.write(24'h000100, 1'b1, 16'h00cd);
		host.read(24'h000100, 1'b0, d, n, w);
		chk_word(d, 16'habcd);
		$display("test mux lanes done");
	endtask

	// Unselected address: never driven, no wait asserted
	task automatic t_unselected();
		host.read(24'h000200, 1'b0, d, n, w);
		chk_bit(n == 12, 1'b1);
		chk_bit(w, 1'b1);
		$display("test unselected done");
	endtask

	// Latched address shown on two ports and held after the cycle
	task automatic t_addr_out();
		host.write(24'h000156, 1'b0, 16'h5555);
		repeat (3) @(posedge clock);
		chk_word(ao_port[15:0], 16'h0156);
		chk_word({11'h000, ao_oe}, 16'h0003);
		$display("test addr out done");
	endtask

	// Other-port address inputs compare without any latch enable
	task automatic t_ext_hit();
		ext_in <= 8'h5a;
		repeat (5) @(posedge clock);
		chk_bit(ext_hit, 1'b1);
		ext_in <= 8'h5b;
		repeat (5) @(posedge clock);
		chk_bit(ext_hit, 1'b0);
		$display("test ext hit done");
	endtask

	// Byte-wide separate bus: single byte on the low data port
	task automatic t_nonmux8();
		chk_word({pd_oe, pc_oe}, 16'h0000);
		host.write(24'h000100, 1'b1, 16'hff77);
		host.write(24'h000101, 1'b1, 16'hff88);
		host.read(24'h000100, 1'b1, d, n, w);
		chk_word({8'h00, d[7:0]}, 16'h0077);
		chk_word({8'h00, pd_oe}, 16'h0000);
		host.read(24'h000101, 1'b1, d, n, w);
		chk_word({8'h00, d[7:0]}, 16'h0088);
		chk_word({pd_oe, pc_oe}, 16'h0000);
		$display("test nonmux8 done");
	endtask

	// Enable clock with R/W; roles switched while the pins are idle
	task automatic t_eclk();
		cfg.rd_role <= mbi_pkg::MBI_RD_ECLK;
		cfg.wr_role <= mbi_pkg::MBI_WR_RNW;
		repeat (3) @(posedge clock);
		host.write(24'h000104, 1'b0, 16'h4321);
		host.read(24'h000104, 1'b0, d, n, w);
		chk_word(d, 16'h4321);
		chk_bit((n == 8) || (n == 9), 1'b1);
		cfg.rd_role <= mbi_pkg::MBI_RD_READ;
		cfg.wr_role <= mbi_pkg::MBI_WR_WRITE;
		repeat (3) @(posedge clock);
		$display("test eclk done");
	endtask

	// Size bit scheme: even byte on the upper lanes, odd on the lower
	task automatic t_size();
		cfg.bc_role <= mbi_pkg::MBI_BC_SIZE;
		host.write(24'h000106, 1'b0, 16'h1122);
		host.write(24'h000106, 1'b1, 16'h33ff);
		host.read(24'h000106, 1'b0, d, n, w);
		chk_word(d, 16'h3322);
		host.read(24'h000107, 1'b1, d, n, w);
		chk_word({8'h00, d[7:0]}, 16'h0022);
		cfg.bc_role <= mbi_pkg::MBI_BC_HIGH_EN;
		$display("test size done");
	endtask

	// Inputs at time zero; roles all default to the first choice
	initial begin
		ext_in = 8'h00;
		cfg = '0;
		cfg.mux_mode = 1'b1;
		cfg.bus16 = 1'b1;
		cfg.ale_high = 1'b1;
		cfg.addr_out_en = 5'h03;
		cfg.addr_out_hi = 5'h02;
		cfg.data_base = 9'h002;
		cfg.prog_base = 9'h003;
		cfg.ext_match = 8'h5a;
		cfg.spare_en = 1'b1;
		t_reset(1'b1, 1'b1);
		t_mux_lanes();
		t_unselected();
		t_addr_out();
		t_ext_hit();
		t_eclk();
		t_size();
		t_reset(1'b0, 1'b0);
		t_nonmux8();
		test_done();
	end

	// Watchdog well above the few hundred cycles the tests take
	initial begin
		repeat (3000) @(posedge clock);
		fail_count++;
		test_done();
	end
endmodule
